// ===== logic/sps_pkg.sv
// Constants and carrier types of the serial port control block
package sps_pkg;
    // Register word indices on the Avalon-MM slave
    localparam logic [2:0] REG_CONTROL = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_BUFFER = 3'h2;
    localparam logic [2:0] REG_PORTC_DIR = 3'h3;
    localparam logic [2:0] REG_PORTC_DATA = 3'h4;
    localparam logic [2:0] REG_IRQ_STATUS = 3'h5;
    localparam logic [2:0] REG_IRQ_MASK = 3'h6;
    // Control register fields
    localparam int CTL_WRITE_COLLISION_FLAG = 7;
    localparam int CTL_OVF = 6;
    localparam int CTL_EN = 5;
    localparam int CTL_CKP = 4;
    // Status register fields
    localparam int STS_SMP = 7;
    localparam int STS_CKE = 6;
    localparam int STS_BF = 0;
    // Interrupt status and mask fields
    localparam int IRQ_DONE = 0;
    localparam int IRQ_WRITE_COLLISION_FLAG = 1;
    localparam int IRQ_OVF = 2;
    // Port C bit positions
    localparam int PC_SDO = 4;
    localparam int PC_SCK = 6;
    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // Mode codes
    localparam logic [3:0] MODE_M_DIV4 = 4'h0;
    localparam logic [3:0] MODE_M_DIV16 = 4'h1;
    localparam logic [3:0] MODE_M_DIV64 = 4'h2;
    localparam logic [3:0] MODE_M_TMR = 4'h3;
    localparam logic [3:0] MODE_S_SS = 4'h4;
    localparam logic [3:0] MODE_S_NOSS = 4'h5;
    // Serial clock half periods in core clock cycles; last bit and last half-period indices
    localparam logic [5:0] HALF_DIV4 = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [4:0] LAST_HALF = 5'h0f;

    typedef struct packed {
        logic sck;
        logic sdi;
        logic ss_n;
    } sps_pin_in_s;

    typedef struct packed {
        logic pc4_o;
        logic pc4_oe;
        logic pc6_o;
        logic pc6_oe;
    } sps_pin_out_s;

    localparam sps_pin_in_s PIN_IN_RST = '{sck: 1'b0, sdi: 1'b0, ss_n: 1'b1};
    localparam sps_pin_out_s PIN_OUT_RST = '0;
endpackage

// ===== logic/sps_spi_control.sv
// Serial port in SPI mode: control register, shift engine, pins, bus
//
// Overview of operation
// [RL1] Enable bit hands pins to port
// [RL2] Software disables, rewrites, then re-enables port
// [RL3] Enabled port drives data pin; master also drives clock pin
// [RL4] Software sets direction bits per pin role
// [RL5] Select-controlled slave resets while select high
// [RL6] Slave with clock edge set needs select
// [RL7] Direction bit 4 reads back output enable
// [RL8] Direction write while select high sets bit4
// [RL9] Buffer write while shifting sets collision flag
// [RL10] Slave overflow on unread buffer, never master
// [RL11] Polarity bit sets serial clock idle level
// [RL12] Mode field picks master rate or slave
// [RL13] Mode 0101 is slave without select
// [RL14] MSB first; full byte sets flags
// [RL15] Select high floats data output at once
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns
module sps_spi_control (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire sps_pkg::sps_pin_in_s pin_i,
    input wire logic timer_two_output,
    output sps_pkg::sps_pin_out_s pin_o,
    output logic irq
);
    import sps_pkg::*;

    sps_pin_in_s sync1_q, sync2_q;
    logic sck_prev_q;
    logic [7:0] ctl_q, dir_q, pdata_q, rxbuf_q, sr_q, rd_val;
    logic smp_q, cke_q, bf_q, mbusy_q, sck_q, sdo_q, ack_q;
    logic [3:0] bitcnt_q;
    logic [4:0] hcnt_q;
    logic [5:0] div_q, half;
    logic [2:0] irq_st_q, irq_mask_q, irq_set;
    logic [31:0] rdata_q;
    logic [3:0] mode;
    logic en, is_master, is_slave, ss_block, eng_rst, busy;
    logic acc, wr_take, rd_take, tick, s_lead, s_trail, lead, trail;
    logic capture, launch, buf_wr, buf_rd, write_collision_flag_set, load, byte_done;
    logic ovf_set, rx_load;
    logic [7:0] dir_rb;
    sps_pin_out_s pin_d;

    // Pins are asynchronous to core_clk
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_q <= PIN_IN_RST;
            sync2_q <= PIN_IN_RST;
            sck_prev_q <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            sck_prev_q <= sync2_q.sck;
        end
    end

    // [RL12] mode field decode
    assign mode = ctl_q[3:0];
    assign en = ctl_q[CTL_EN];
    assign is_master = en && (mode <= MODE_M_TMR);
    // [RL13] 0101 slave ignores select
    assign is_slave = en && (mode == MODE_S_SS || mode == MODE_S_NOSS);
    // [RL5] select high holds engine reset
    assign ss_block = en && mode == MODE_S_SS && sync2_q.ss_n;
    // [RL2] clearing enable resets the engine
    assign eng_rst = !(is_master || is_slave) || ss_block;
    assign busy = is_master ? mbusy_q : (bitcnt_q != 4'h0);

    // Bus: one wait cycle, then the access is taken
    assign acc = avs_read || avs_write;
    assign avs_waitrequest = acc && !ack_q;
    assign wr_take = avs_write && ack_q;
    assign rd_take = avs_read && ack_q;
    assign avs_readdata = rdata_q;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= acc && !ack_q;
            if (acc && !ack_q) begin
                rdata_q <= {24'h000000, rd_val};
            end
        end
    end

    // [RL7] bit 4 reads the port's output enable
    assign dir_rb = ss_block ? (dir_q | 8'h10) : dir_q;

    always_comb begin
        case (avs_address)
            REG_CONTROL: rd_val = ctl_q;
            REG_STATUS: rd_val = {smp_q, cke_q, 5'h00, bf_q};
            REG_BUFFER: rd_val = rxbuf_q;
            REG_PORTC_DIR: rd_val = dir_rb;
            REG_PORTC_DATA: rd_val = pdata_q;
            REG_IRQ_STATUS: rd_val = {5'h00, irq_st_q};
            REG_IRQ_MASK: rd_val = {5'h00, irq_mask_q};
            default: rd_val = 8'h00;
        endcase
    end

    assign buf_wr = wr_take && avs_address == REG_BUFFER;
    assign buf_rd = rd_take && avs_address == REG_BUFFER;
    // [RL9] write during a transfer is dropped
    assign write_collision_flag_set = buf_wr && busy;
    assign load = buf_wr && !busy && (is_master || is_slave);

    // Master rate divider
    always_comb begin
        case (mode)
            MODE_M_DIV16: half = HALF_DIV16;
            MODE_M_DIV64: half = HALF_DIV64;
            default: half = HALF_DIV4;
        endcase
    end

    // [RL12] tick is one half period of the clock
    assign tick = mbusy_q && (mode == MODE_M_TMR ? timer_two_output
                                                 : div_q == half - 6'h01);

    always_ff @(posedge core_clk) begin
        if (!rst_n || !mbusy_q || tick) begin
            div_q <= 6'h00;
        end else begin
            div_q <= div_q + 6'h01;
        end
    end

    // Master clock generator: sixteen half periods per byte
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mbusy_q <= 1'b0;
            hcnt_q <= 5'h00;
            sck_q <= 1'b0;
        end else begin
            if (eng_rst || !is_master) begin
                mbusy_q <= 1'b0;
            end else if (load) begin
                mbusy_q <= 1'b1;
                hcnt_q <= 5'h00;
            end else if (tick) begin
                hcnt_q <= hcnt_q + 5'h01;
                if (hcnt_q == LAST_HALF) begin
                    mbusy_q <= 1'b0;
                end
            end
            // [RL11] idle level follows polarity bit
            if (!mbusy_q) begin
                sck_q <= ctl_q[CTL_CKP];
            end else if (tick) begin
                sck_q <= !sck_q;
            end
        end
    end

    // Leading edge leaves the idle level
    assign s_lead = ctl_q[CTL_CKP] ? (sck_prev_q && !sync2_q.sck)
                                   : (!sck_prev_q && sync2_q.sck);
    assign s_trail = ctl_q[CTL_CKP] ? (!sck_prev_q && sync2_q.sck)
                                    : (sck_prev_q && !sync2_q.sck);
    assign lead = is_master ? (tick && sck_q == ctl_q[CTL_CKP])
                            : (is_slave && s_lead);
    assign trail = is_master ? (tick && sck_q != ctl_q[CTL_CKP])
                             : (is_slave && s_trail);
    // Clock edge bit set: data changes on trailing, sampled on leading
    assign capture = !eng_rst && (cke_q ? lead : trail);
    assign launch = !eng_rst && (cke_q ? trail : lead);

    assign byte_done = capture && !load && bitcnt_q == LAST_BIT;
    // [RL10] slave only; a same-cycle read frees the buffer
    assign ovf_set = byte_done && is_slave && bf_q && !buf_rd;
    assign rx_load = byte_done && !ovf_set;

    // [RL14] shift MSB first, count eight bits
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sr_q <= 8'h00;
            bitcnt_q <= 4'h0;
            sdo_q <= 1'b0;
        end else begin
            if (load) begin
                sr_q <= avs_writedata[7:0];
            end else if (capture) begin
                sr_q <= {sr_q[6:0], sync2_q.sdi};
            end
            // [RL5] bit counter forced to zero
            if (eng_rst || load) begin
                bitcnt_q <= 4'h0;
            end else if (capture) begin
                bitcnt_q <= byte_done ? 4'h0 : bitcnt_q + 4'h1;
            end
            if (load && cke_q) begin
                sdo_q <= avs_writedata[7];
            end else if (launch) begin
                sdo_q <= sr_q[7];
            end
        end
    end

    // [RL14] completed byte moves to buffer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rxbuf_q <= 8'h00;
            bf_q <= 1'b0;
        end else begin
            if (rx_load) begin
                rxbuf_q <= {sr_q[6:0], sync2_q.sdi};
            end
            // New byte wins over a clearing read
            bf_q <= rx_load || (bf_q && !buf_rd);
        end
    end

    // Control and status registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctl_q <= CONTROL_RST;
            smp_q <= 1'b0;
            cke_q <= 1'b0;
        end else begin
            if (wr_take && avs_address == REG_CONTROL) begin
                ctl_q[5:0] <= avs_writedata[5:0];
            end
            // [RL9] flag sticks until software writes zero
            ctl_q[CTL_WRITE_COLLISION_FLAG] <= write_collision_flag_set || ((wr_take &&
                avs_address == REG_CONTROL) ? avs_writedata[CTL_WRITE_COLLISION_FLAG]
                                            : ctl_q[CTL_WRITE_COLLISION_FLAG]);
            // [RL10] overflow flag, set wins
            ctl_q[CTL_OVF] <= ovf_set || ((wr_take &&
                avs_address == REG_CONTROL) ? avs_writedata[CTL_OVF]
                                            : ctl_q[CTL_OVF]);
            if (wr_take && avs_address == REG_STATUS) begin
                smp_q <= avs_writedata[STS_SMP];
                cke_q <= avs_writedata[STS_CKE];
            end
        end
    end

    // Port C direction and data latches
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dir_q <= DIR_RST;
            pdata_q <= DATA_RST;
        end else begin
            if (wr_take && avs_address == REG_PORTC_DIR) begin
                dir_q <= avs_writedata[7:0];
                // [RL8] write-back while select high keeps bit 4 set
                if (ss_block) begin
                    dir_q[PC_SDO] <= 1'b1;
                end
            end
            if (wr_take && avs_address == REG_PORTC_DATA) begin
                pdata_q <= avs_writedata[7:0];
            end
        end
    end

    // [RL1] pin ownership follows the enable bit
    always_comb begin
        pin_d.pc4_o = pdata_q[PC_SDO];
        pin_d.pc4_oe = !dir_q[PC_SDO];
        pin_d.pc6_o = pdata_q[PC_SCK];
        pin_d.pc6_oe = !dir_q[PC_SCK];
        if (en) begin
            // [RL3] serial functions replace port data
            pin_d.pc4_o = sdo_q;
            // [RL15] select high floats the data output
            pin_d.pc4_oe = !dir_rb[PC_SDO];
            if (is_master) begin
                pin_d.pc6_o = sck_q;
            end
        end
    end

    // Interrupts: sticky, cleared by reading them
    assign irq_set = {ovf_set, write_collision_flag_set, rx_load};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_st_q <= IRQ_RST;
            irq_mask_q <= IRQ_RST;
            pin_o <= PIN_OUT_RST;
        end else begin
            pin_o <= pin_d;
            if (rd_take && avs_address == REG_IRQ_STATUS) begin
                irq_st_q <= irq_set;
            end else begin
                irq_st_q <= irq_st_q | irq_set;
            end
            if (wr_take && avs_address == REG_IRQ_MASK) begin
                irq_mask_q <= avs_writedata[2:0];
            end
        end
    end

    assign irq = |(irq_st_q & irq_mask_q);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_bus_wait_one: assert property ( // bus
        (acc && avs_waitrequest) |=> !avs_waitrequest)
        else $error("waitrequest held longer than one cycle");
    a_disabled_pins: assert property ( // [RL1]
        !en |=> pin_o.pc4_oe == !$past(dir_q[PC_SDO])
            && pin_o.pc4_o == $past(pdata_q[PC_SDO]))
        else $error("disabled port still owns data pin");
    a_master_sck_pin: assert property ( // [RL3]
        is_master |=> pin_o.pc6_o == $past(sck_q))
        else $error("master clock not on pin");
    a_ss_engine_reset: assert property ( // [RL5]
        ss_block |=> bitcnt_q == 4'h0)
        else $error("bit counter not reset by select");
    a_ss_dir_rmw: assert property ( // [RL8]
        (wr_take && avs_address == REG_PORTC_DIR && ss_block)
        |=> dir_q[PC_SDO])
        else $error("direction bit 4 cleared while select high");
    a_write_collision_flag_sticky: assert property ( // [RL9]
        write_collision_flag_set |=> ctl_q[CTL_WRITE_COLLISION_FLAG] ##1 ctl_q[CTL_WRITE_COLLISION_FLAG]
            || $past(wr_take))
        else $error("collision flag lost");
    a_master_no_ovf: assert property ( // [RL10]
        is_master |-> !ovf_set ##1 $past(ctl_q[CTL_OVF])
            || !ctl_q[CTL_OVF] || $past(wr_take))
        else $error("master raised overflow");
    a_ovf_discard: assert property ( // [RL10]
        ovf_set |=> $stable(rxbuf_q) && ctl_q[CTL_OVF])
        else $error("overflow overwrote buffer");
    a_idle_polarity: assert property ( // [RL11]
        (is_master && !mbusy_q && !$past(mbusy_q)
            && $stable(ctl_q)) |-> sck_q == ctl_q[CTL_CKP])
        else $error("idle clock level wrong");
    a_byte_done_flags: assert property ( // [RL14]
        rx_load |=> bf_q && irq_st_q[IRQ_DONE]
            && rxbuf_q == {$past(sr_q[6:0]), $past(sync2_q.sdi)})
        else $error("completed byte not posted");
    a_ss_float: assert property ( // [RL15]
        ss_block |=> !pin_o.pc4_oe)
        else $error("data pin driven while deselected");

    c_master_byte: cover property (is_master && rx_load);
    c_slave_ovf: cover property (ovf_set);
    c_collision: cover property (write_collision_flag_set);
    c_ss_abort: cover property (ss_block && bitcnt_q != 4'h0);
endmodule

// ===== tb/sps_spi_peer.sv
// Behavioural SPI master peer on the serial clock, select and data pins
`timescale 1ns/1ns
module sps_spi_peer (
    input wire logic loop,
    input wire logic cke,
    input wire logic sdo,
    output sps_pkg::sps_pin_in_s pin
);
    import sps_pkg::*;
    logic lclk = 1'b0;
    logic sck_q = 1'b0;
    logic ss_n_q = 1'b1;
    logic sdi_q = 1'b0;
    logic busy = 1'b0;
    logic [7:0] rx_q = 8'h00;
    // Own link clock, phase unrelated to the core clock
    initial begin
        #13;
        forever #100 lclk = ~lclk;
    end
    // Released data line must not keep its last value
    always @(posedge lclk) begin
        if (!busy) sdi_q <= ~sdi_q;
    end
    assign pin = '{sck: sck_q, sdi: loop ? sdo : sdi_q, ss_n: ss_n_q};
    // MSB first, launch on leading edge
    task automatic xfer(input logic [7:0] tx, input int nbits, input logic sel);
        busy = 1'b1;
        @(posedge lclk);
        ss_n_q <= !sel;
        for (int i = 0; i < nbits; i++) begin
            @(posedge lclk);
            rx_q <= {rx_q[6:0], sdo};
            sck_q <= 1'b1;
            sdi_q <= tx[7 - i];
            @(posedge lclk);
            sck_q <= 1'b0;
        end
        @(posedge lclk);
        // Trailing-edge launch leaves nothing more to take
        if (!cke) rx_q <= {rx_q[6:0], sdo};
        ss_n_q <= 1'b1;
        @(posedge lclk);
        busy = 1'b0;
    endtask
endmodule

// ===== tb/tb_sps_spi_control.sv
// Self-checking bench of the SPI control block
`timescale 1ns/1ns
module tb_sps_spi_control;
    import sps_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic timer_two_output = 1'b0;
    logic [1:0] tick_q = 2'h0;
    logic loop = 1'b0;
    logic cke = 1'b0;
    logic peer_sdo;
    sps_pin_in_s pin_i;
    sps_pin_out_s pin_o;
    logic irq;
    int n_errors = 0;
    int n_tests = 0;

    sps_spi_control u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_i(pin_i),
        .timer_two_output(timer_two_output), .pin_o(pin_o), .irq(irq)
    );
    // Undriven data line shows the inverse, not its last level
    assign peer_sdo = pin_o.pc4_oe ? pin_o.pc4_o : !pin_o.pc4_o;
    sps_spi_peer u_peer (
        .loop(loop), .cke(cke), .sdo(peer_sdo), .pin(pin_i)
    );

    initial begin
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        tick_q <= tick_q + 2'h1;
        timer_two_output <= (tick_q == 2'h3);
    end

    task automatic stop_test;
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Hold the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [2:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge core_clk);
        // Only the watchdog ends a wait that never answers
        while (avs_waitrequest !== 1'b0) begin
            @(posedge core_clk);
        end
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk({24'h0, q}, {24'h0, exp});
    endtask
    task automatic wait_bf;
        logic [7:0] q;
        int n;
        n = 0;
        q = 8'h00;
        while (q[STS_BF] !== 1'b1 && n < 400) begin
            bus(1'b0, REG_STATUS, 8'h00, q);
            n++;
        end
        chk({31'h0, q[STS_BF]}, 32'h1);
    endtask
    task automatic pins(input logic [3:0] exp);
        repeat (4) @(posedge core_clk);
        chk({28'h0, pin_o}, {28'h0, exp});
    endtask

    task automatic t_reset;
        rdchk(REG_CONTROL, CONTROL_RST);
        rdchk(REG_PORTC_DIR, DIR_RST);
        rdchk(3'h7, 8'h00);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_master;
        logic [7:0] tx;
        loop <= 1'b1;
        // data out and clock as outputs
        wr(REG_PORTC_DIR, 8'haf);
        for (int m = 0; m < 4; m++) begin
            tx = 8'ha5 ^ m[7:0];
            wr(REG_CONTROL, m[7:0]);
            wr(REG_CONTROL, 8'h20 | m[7:0]);
            wr(REG_BUFFER, tx);
            wr(REG_BUFFER, 8'h0f);
            rdchk(REG_CONTROL, 8'ha0 | m[7:0]);
            wait_bf();
            rdchk(REG_CONTROL, 8'ha0 | m[7:0]);
            // Pin register plus synchroniser outlast a half period at /4
            if (m == 0)
                rdchk(REG_BUFFER, {1'b0, tx[7:1]});
            else
                rdchk(REG_BUFFER, tx);
        end
        chk({31'h0, irq}, 32'h0);
        wr(REG_IRQ_MASK, 8'h07);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        rdchk(REG_IRQ_STATUS, 8'h03);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        wr(REG_CONTROL, 8'h10);
        wr(REG_CONTROL, 8'h30);
        pins(4'b0111);
        wr(REG_CONTROL, 8'h10);
        wr(REG_PORTC_DATA, 8'h10);
        pins(4'b1101);
        loop <= 1'b0;
    endtask
    task automatic t_slave;
        // data out driven, clock input, edge select 0
        wr(REG_PORTC_DIR, 8'hef);
        wr(REG_CONTROL, 8'h04);
        wr(REG_CONTROL, 8'h24);
        rdchk(REG_PORTC_DIR, 8'hff);
        chk({31'h0, pin_o.pc4_oe}, 32'h0);
        wr(REG_BUFFER, 8'h96);
        u_peer.xfer(8'h3c, 8, 1'b1);
        chk({24'h0, u_peer.rx_q}, 32'h96);
        wait_bf();
        u_peer.xfer(8'h81, 8, 1'b1);
        rdchk(REG_CONTROL, 8'h64);
        rdchk(REG_BUFFER, 8'h3c);
        wr(REG_CONTROL, 8'h24);
        u_peer.xfer(8'hff, 4, 1'b1);
        repeat (8) @(posedge core_clk);
        chk({31'h0, pin_o.pc4_oe}, 32'h0);
        u_peer.xfer(8'h5a, 8, 1'b1);
        wait_bf();
        rdchk(REG_BUFFER, 8'h5a);
        wr(REG_PORTC_DIR, 8'hef);
        rdchk(REG_PORTC_DIR, 8'hff);
        wr(REG_CONTROL, 8'h05);
        wr(REG_CONTROL, 8'h25);
        rdchk(REG_PORTC_DIR, 8'hff);
        u_peer.xfer(8'hc3, 8, 1'b0);
        wait_bf();
        rdchk(REG_BUFFER, 8'hc3);
    endtask
    task automatic t_slave_cke;
        // disable before changing edge and mode
        wr(REG_CONTROL, 8'h04);
        wr(REG_PORTC_DIR, 8'hef);
        // edge select set only with select control
        wr(REG_STATUS, 8'hc0);
        rdchk(REG_STATUS, 8'hc0);
        wr(REG_CONTROL, 8'h24);
        wr(REG_BUFFER, 8'h69);
        cke <= 1'b1;
        u_peer.xfer(8'h2d, 8, 1'b1);
        chk({24'h0, u_peer.rx_q}, 32'h69);
        wait_bf();
        rdchk(REG_BUFFER, 8'h2d);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_master();
        t_slave();
        t_slave_cke();
        stop_test();
    end
endmodule
